/* File: pkg/suspend_pkg.sv */
package suspend_pkg;

  ////////////////////////////////////////////////////////////
  // clock and timing
  localparam int CLK_PERIOD_NS = 25;   // 40 MHz system clock
  localparam int CYC_W         = 8;    // width of every cycle count

  // entry step delays, measured from the entry trigger
  localparam int ENTRY_WRITE_PROTECT_DELAY_NS = 100;
  localparam int ENTRY_STATUS_DELAY_NS        = 200;
  localparam int ENTRY_OUTPUT_SWITCH_DELAY_NS = 300;
  localparam int ENTRY_INPUT_BLOCK_DELAY_NS   = 400;
  // exit step delays, measured from the exit trigger
  localparam int EXIT_INPUT_RELEASE_DELAY_NS  = 200;
  localparam int EXIT_STATUS_DELAY_NS         = 400;
  localparam int WAKE_PIN_STATUS_DELAY_NS     = 400;

  // least time rounds up, never below one cycle
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam logic [CYC_W-1:0] ENTRY_WP_CYC     = CYC_W'(ns_to_cyc(ENTRY_WRITE_PROTECT_DELAY_NS));
  localparam logic [CYC_W-1:0] ENTRY_STATUS_CYC = CYC_W'(ns_to_cyc(ENTRY_STATUS_DELAY_NS));
  localparam logic [CYC_W-1:0] ENTRY_SWITCH_CYC = CYC_W'(ns_to_cyc(ENTRY_OUTPUT_SWITCH_DELAY_NS));
  localparam logic [CYC_W-1:0] ENTRY_BLOCK_CYC  = CYC_W'(ns_to_cyc(ENTRY_INPUT_BLOCK_DELAY_NS));
  localparam logic [CYC_W-1:0] EXIT_RELEASE_CYC = CYC_W'(ns_to_cyc(EXIT_INPUT_RELEASE_DELAY_NS));
  localparam logic [CYC_W-1:0] EXIT_STATUS_CYC  = CYC_W'(ns_to_cyc(EXIT_STATUS_DELAY_NS));
  localparam logic [CYC_W-1:0] PIN_STATUS_CYC   = CYC_W'(ns_to_cyc(WAKE_PIN_STATUS_DELAY_NS));

  ////////////////////////////////////////////////////////////
  // register map, byte offsets
  localparam logic [3:0] CTRL_OFS   = 4'h0;
  localparam logic [3:0] MASK_OFS   = 4'h4;
  localparam logic [3:0] CYCLE_OFS  = 4'h8;
  localparam logic [3:0] STATUS_OFS = 4'hC;

  localparam int WAKE_PINS = 8;        // wake pins monitored at most
  localparam int CTRL_W    = 5;        // used bits of the control word
  localparam int OUT_CYC_LSB = 0;      // output release count field
  localparam int WR_CYC_LSB  = 8;      // write release count field
  localparam int STATUS_W    = 8;      // used bits of the status word

  // reset values
  localparam logic [CTRL_W-1:0]    CTRL_RESET    = 5'h00;
  localparam logic [WAKE_PINS-1:0] MASK_RESET    = 8'h00;
  localparam logic [CYC_W-1:0]     OUT_CYC_RESET = 8'h04;
  localparam logic [CYC_W-1:0]     WR_CYC_RESET  = 8'h05;

  // control word, bit 4 first
  typedef struct packed {
    logic wake_reset;      // bit 4: global set/reset on exit
    logic drive_awake;     // bit 3: drive awake high, else open drain
    logic multipin_en;     // bit 2: wake pins gate the exit
    logic handshake_en;    // bit 1: sleep request/ack handshake present
    logic suspend_en;      // bit 0: suspend feature enabled
  } ctrl_t;

  // release counts
  typedef struct packed {
    logic [CYC_W-1:0] write_cyc;
    logic [CYC_W-1:0] out_cyc;
  } cycles_t;

  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_REQ,
    ST_ENTRY,
    ST_SLEEP,
    ST_EXIT,
    ST_WAIT_AWAKE,
    ST_RELEASE
  } state_t;

endpackage

/* File: rtl/bit_sync.sv */
`timescale 1ns/1ps
// two-stage synchroniser for pins from outside the clock domain
module bit_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // pin side and clock side
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta_reg;  // first stage, read by the second only

  ////////////////////////////////////////////////////////////
  // both stages in one process, no tap on the first
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= '0;
      dout     <= '0;
    end else begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end

endmodule

/* File: rtl/step_timer.sv */
`timescale 1ns/1ps
// saturating up-counter of whole clock cycles
module step_timer #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // control and count
  input  wire logic         clear,
  output logic      [W-1:0] count
);

  ////////////////////////////////////////////////////////////
  // zero while cleared, then one per cycle; holds at full scale
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count <= '0;
    end else if (clear) begin
      count <= '0;
    end else if (count != {W{1'b1}}) begin
      count <= count + W'(1);
    end
  end

endmodule

/* File: rtl/suspend_wake_sequencer.sv */
`timescale 1ns/1ps
// Function
// - suspend input ignored unless feature enabled
// - no handshake: suspend starts entry at once
// - handshake: raise sleep request after suspend
// - handshake: entry waits for sleep acknowledge
// - capture hold values at entry, present later
// - write protect storage after protect delay
// - drive awake low after status delay
// - outputs take sleep behaviour after switch delay
// - lastly block inputs, freeze interconnect
// - configuration done stays high while asleep
// - suspend low starts exit without wake pins
// - multipin: suspend low and enabled pin high
// - release inputs, storage still write protected
// - awake driven high or released open drain
// - wake timing starts from awake seen high
// - release outputs after output release count
// - enable writes after write release count
// - global set/reset on exit only if configured
module suspend_wake_sequencer (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // avalon-mm register slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // system pins
  input  wire logic        suspend_in,
  input  wire logic [7:0]  wake_pin,
  input  wire logic        awake_in,
  output logic             awake_out,
  output logic             awake_oe,
  output logic             config_done,
  // user design handshake
  input  wire logic        sleep_ack_in,
  output logic             sleep_request_out,
  // global fabric controls
  output logic             global_write_en,
  output logic             outputs_sleep,
  output logic             input_block,
  output logic             capture_hold,
  output logic             global_set_reset
);

  ////////////////////////////////////////////////////////////
  // declarations

  localparam int CW = suspend_pkg::CYC_W;

  suspend_pkg::ctrl_t   ctrl_reg;      // feature options
  suspend_pkg::cycles_t cycles_reg;    // release counts
  logic [7:0]           mask_reg;      // enabled wake pins

  suspend_pkg::state_t  state_reg;     // sequencer state
  suspend_pkg::state_t  state_next;

  logic                 by_pin_reg;    // exit was triggered by a wake pin
  logic                 suspend_s;     // synchronised suspend
  logic [7:0]           wake_s;        // synchronised wake pins
  logic                 awake_s;       // synchronised awake level
  logic [CW-1:0]        seq_cnt;       // cycles since entry/exit trigger
  logic [CW-1:0]        rel_cnt;       // cycles since awake seen high
  logic                 seq_clear;
  logic                 rel_clear;
  logic                 wake_hit;      // exit condition met
  logic                 out_due;       // output release reached
  logic                 wr_due;        // write release reached
  logic [CW-1:0]        status_cyc;    // awake delay for this exit
  logic                 bus_req;
  logic                 bus_take;      // request accepted this edge

  ////////////////////////////////////////////////////////////
  // helpers

  // true once a step counter has reached a release count;
  // a count of zero behaves as one so a release never lands early
  function automatic logic reached(input logic [CW-1:0] cnt,
                                   input logic [CW-1:0] lim);
    logic [CW:0] c1;
    c1 = {1'b0, cnt} + (CW+1)'(1);
    return c1 >= {1'b0, lim};
  endfunction

  ////////////////////////////////////////////////////////////
  // pin synchronisers

  // all three come from the board, not from this clock
  bit_sync #(.W(10)) u_pin_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .din   ({suspend_in, awake_in, wake_pin}),
    .dout  ({suspend_s, awake_s, wake_s})
  );

  ////////////////////////////////////////////////////////////
  // step timers

  // entry and exit steps share one counter; they never overlap
  assign seq_clear = (state_reg != suspend_pkg::ST_ENTRY) &&
                     (state_reg != suspend_pkg::ST_EXIT);

  step_timer #(.W(CW)) u_seq_timer (
    .clk   (clk),
    .rst_b (rst_b),
    .clear (seq_clear),
    .count (seq_cnt)
  );

  // held at zero until awake has been seen high
  assign rel_clear = (state_reg != suspend_pkg::ST_RELEASE);

  step_timer #(.W(CW)) u_rel_timer (
    .clk   (clk),
    .rst_b (rst_b),
    .clear (rel_clear),
    .count (rel_cnt)
  );

  ////////////////////////////////////////////////////////////
  // decode of step points

  // a wake pin high already when suspend falls counts as well
  assign wake_hit = !suspend_s &&
                    (!ctrl_reg.multipin_en || |(wake_s & mask_reg));

  assign out_due = reached(rel_cnt, cycles_reg.out_cyc);
  assign wr_due  = reached(rel_cnt, cycles_reg.write_cyc);

  // awake delay depends on what ended the sleep
  assign status_cyc = by_pin_reg ? suspend_pkg::PIN_STATUS_CYC
                                 : suspend_pkg::EXIT_STATUS_CYC;

  ////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      suspend_pkg::ST_IDLE: begin
        // a disabled feature leaves the pin without effect
        if (ctrl_reg.suspend_en && suspend_s) begin
          if (ctrl_reg.handshake_en) begin
            state_next = suspend_pkg::ST_REQ;
          end else begin
            state_next = suspend_pkg::ST_ENTRY;
          end
        end
      end
      suspend_pkg::ST_REQ: begin
        // user logic owns the delay; suspend withdrawn aborts it
        if (!suspend_s) begin
          state_next = suspend_pkg::ST_IDLE;
        end else if (sleep_ack_in) begin
          state_next = suspend_pkg::ST_ENTRY;
        end
      end
      suspend_pkg::ST_ENTRY: begin
        // last step ends entry
        if (seq_cnt == suspend_pkg::ENTRY_BLOCK_CYC) begin
          state_next = suspend_pkg::ST_SLEEP;
        end
      end
      suspend_pkg::ST_SLEEP: begin
        if (wake_hit) begin
          state_next = suspend_pkg::ST_EXIT;
        end
      end
      suspend_pkg::ST_EXIT: begin
        if (seq_cnt == status_cyc) begin
          state_next = suspend_pkg::ST_WAIT_AWAKE;
        end
      end
      suspend_pkg::ST_WAIT_AWAKE: begin
        // the pin itself, not our own release, starts the timers
        if (awake_s) begin
          state_next = suspend_pkg::ST_RELEASE;
        end
      end
      suspend_pkg::ST_RELEASE: begin
        if (out_due && wr_due) begin
          state_next = suspend_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = suspend_pkg::ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= suspend_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////
  // exit cause, caught on the exit trigger

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      by_pin_reg <= 1'b0;
    end else if (state_reg == suspend_pkg::ST_SLEEP && wake_hit) begin
      by_pin_reg <= ctrl_reg.multipin_en;
    end
  end

  ////////////////////////////////////////////////////////////
  // sleep request to the user design

  // held until the device is fully awake again
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sleep_request_out <= 1'b0;
    end else if (state_next == suspend_pkg::ST_IDLE) begin
      sleep_request_out <= 1'b0;
    end else if (state_next == suspend_pkg::ST_REQ) begin
      sleep_request_out <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////
  // hold-value capture strobe

  // one pulse as entry starts; pads show it only once
  // outputs_sleep rises
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      capture_hold <= 1'b0;
    end else begin
      capture_hold <= (state_reg != suspend_pkg::ST_ENTRY) &&
                      (state_next == suspend_pkg::ST_ENTRY);
    end
  end

  ////////////////////////////////////////////////////////////
  // global write enable

  // stays off through input release so nothing is corrupted
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      global_write_en <= 1'b1;
    end else if (state_reg == suspend_pkg::ST_ENTRY &&
                 seq_cnt == suspend_pkg::ENTRY_WP_CYC) begin
      global_write_en <= 1'b0;
    end else if (state_reg == suspend_pkg::ST_RELEASE && wr_due) begin
      global_write_en <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////
  // global output switch

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      outputs_sleep <= 1'b0;
    end else if (state_reg == suspend_pkg::ST_ENTRY &&
                 seq_cnt == suspend_pkg::ENTRY_SWITCH_CYC) begin
      outputs_sleep <= 1'b1;
    end else if (state_reg == suspend_pkg::ST_RELEASE && out_due) begin
      outputs_sleep <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////
  // input and interconnect block

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      input_block <= 1'b0;
    end else if (state_reg == suspend_pkg::ST_ENTRY &&
                 seq_cnt == suspend_pkg::ENTRY_BLOCK_CYC) begin
      input_block <= 1'b1;
    end else if (state_reg == suspend_pkg::ST_EXIT &&
                 seq_cnt == suspend_pkg::EXIT_RELEASE_CYC) begin
      input_block <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////
  // optional global set/reset on exit

  // off by default so the pre-sleep state survives
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      global_set_reset <= 1'b0;
    end else begin
      global_set_reset <= ctrl_reg.wake_reset &&
                          state_reg == suspend_pkg::ST_EXIT &&
                          seq_cnt == suspend_pkg::EXIT_RELEASE_CYC;
    end
  end

  ////////////////////////////////////////////////////////////
  // awake pin driver

  // asleep: driven low; awake: driven high or left to the pull-up
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      awake_out <= 1'b0;
      awake_oe  <= 1'b0;
    end else if (state_reg == suspend_pkg::ST_ENTRY &&
                 seq_cnt == suspend_pkg::ENTRY_STATUS_CYC) begin
      awake_out <= 1'b0;
      awake_oe  <= 1'b1;
    end else if ((state_reg == suspend_pkg::ST_EXIT &&
                  seq_cnt == status_cyc) ||
                 state_reg == suspend_pkg::ST_IDLE) begin
      // open drain lets several devices wake in step
      awake_out <= ctrl_reg.drive_awake;
      awake_oe  <= ctrl_reg.drive_awake;
    end
  end

  ////////////////////////////////////////////////////////////
  // configuration done

  // configuration is retained, so sleep never lowers it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      config_done <= 1'b0;
    end else begin
      config_done <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////
  // avalon-mm slave

  assign bus_req  = avs_read || avs_write;
  assign bus_take = bus_req && !avs_waitrequest;

  // one wait cycle per access, then one released cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
    end else if (!avs_waitrequest) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !bus_req;
    end
  end

  // read data made ready while waitrequest is still high
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest) begin
      case (avs_address)
        suspend_pkg::CTRL_OFS:   avs_readdata <= 32'(ctrl_reg);
        suspend_pkg::MASK_OFS:   avs_readdata <= 32'(mask_reg);
        suspend_pkg::CYCLE_OFS:  avs_readdata <= 32'(cycles_reg);
        suspend_pkg::STATUS_OFS: begin
          avs_readdata <= 32'({awake_s, sleep_request_out, input_block,
                               outputs_sleep, global_write_en,
                               3'(state_reg)});
        end
        default:                 avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // writes land at the accepting edge; unmapped ones are dropped;
  // the write release count is not checked against the output one
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_reg   <= suspend_pkg::CTRL_RESET;
      mask_reg   <= suspend_pkg::MASK_RESET;
      cycles_reg <= {suspend_pkg::WR_CYC_RESET, suspend_pkg::OUT_CYC_RESET};
    end else if (bus_take && avs_write) begin
      case (avs_address)
        suspend_pkg::CTRL_OFS: begin
          ctrl_reg <= avs_writedata[suspend_pkg::CTRL_W-1:0];
        end
        suspend_pkg::MASK_OFS: begin
          mask_reg <= avs_writedata[7:0];
        end
        suspend_pkg::CYCLE_OFS: begin
          cycles_reg.out_cyc   <= avs_writedata[suspend_pkg::OUT_CYC_LSB +: CW];
          cycles_reg.write_cyc <= avs_writedata[suspend_pkg::WR_CYC_LSB +: CW];
        end
        default: begin
          ctrl_reg <= ctrl_reg;
        end
      endcase
    end
  end

endmodule

/* File: tb/suspend_wake_sequencer_assertions.sv */
`timescale 1ns/1ps
// pin checker; shadows the control word from accepted bus writes
module seq_checker (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // register bus
  input wire logic [3:0]  avs_address,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic        avs_waitrequest,
  // pins and fabric controls
  input wire logic        awake_out,
  input wire logic        awake_oe,
  input wire logic        config_done,
  input wire logic        sleep_ack_in,
  input wire logic        sleep_request_out,
  input wire logic        global_write_en,
  input wire logic        outputs_sleep,
  input wire logic        input_block,
  input wire logic        capture_hold,
  input wire logic        global_set_reset
);
  logic [4:0] ctrl_sh;  // control word as software last wrote it
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////
  // shadow only counts writes the slave accepted
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) ctrl_sh <= 5'h00;
    else if (avs_write && !avs_waitrequest && avs_address == 4'h0) ctrl_sh <= avs_writedata[4:0];
  end
  ////////////////////////////////
  AST_CFG_DONE: assert property ($past(rst_b) |-> config_done) else $error("done low");
  AST_OFF: assert property (!ctrl_sh[0] |-> !capture_hold && !input_block) else $error("entry while off");
  AST_NO_HS: assert property (!ctrl_sh[1] |-> !sleep_request_out) else $error("stray request");
  AST_REQ_ACK: assert property (capture_hold && ctrl_sh[1] |-> sleep_request_out && $past(sleep_ack_in))
    else $error("entry without ack");
  AST_ENTRY_WP: assert property (capture_hold |-> ##5 $fell(global_write_en)) else $error("protect late");
  AST_ENTRY_STEPS: assert property ($fell(global_write_en) |-> ##3 !(awake_oe && !awake_out)
    ##1 (awake_oe && !awake_out) ##4 $rose(outputs_sleep) ##4 $rose(input_block))
    else $error("entry steps off");
  AST_EXIT: assert property ($fell(input_block) |-> !global_write_en && outputs_sleep ##7 (awake_oe && !awake_out)
    ##1 (awake_oe == ctrl_sh[3] && awake_out == ctrl_sh[3])) else $error("exit steps off");
  // the pin takes a new drive option one edge after the write lands
  AST_OD: assert property (awake_oe && !ctrl_sh[3] && !$past(ctrl_sh[3]) |-> !awake_out)
    else $error("awake driven high");
  AST_GSR: assert property (global_set_reset |-> ctrl_sh[4] && $fell(input_block) ##1 !global_set_reset)
    else $error("bad set reset");
  AST_REL_ORDER: assert property ($rose(global_write_en) |-> !outputs_sleep && !input_block)
    else $error("writes before outputs");
  // main scenarios reached
  cover property ($rose(input_block));
  cover property (global_set_reset);
  cover property ($rose(global_write_en));
endmodule
bind suspend_wake_sequencer seq_checker u_seq_checker (.clk, .rst_b, .avs_address, .avs_write, .avs_writedata,
  .avs_waitrequest, .awake_out, .awake_oe, .config_done, .sleep_ack_in, .sleep_request_out, .global_write_en,
  .outputs_sleep, .input_block, .capture_hold, .global_set_reset);

/* File: tb/sys_ctrl_model.sv */
`timescale 1ns/1ps
// user logic acknowledge plus awake wire with system pull-up
module sys_ctrl_model (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst_b,
  // device side
  input wire logic       sleep_request_out,
  input wire logic       awake_out,
  input wire logic       awake_oe,
  output logic           sleep_ack_in,
  output logic           awake_in,
  // bench knobs
  input wire logic [7:0] ack_wait,
  input wire logic       ext_low
);
  logic [7:0] req_cnt;  // cycles of pending request
  ////////////////////////////////
  // finish pending work, then acknowledge until request drops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      req_cnt <= 8'h00;
      sleep_ack_in <= 1'b0;
    end else if (!sleep_request_out) begin
      req_cnt <= 8'h00;
      sleep_ack_in <= 1'b0;
    end else begin
      req_cnt <= req_cnt + 8'h01;
      sleep_ack_in <= (req_cnt >= ack_wait);
    end
  end
  // released wire rises by pull-up unless the system holds it low
  assign awake_in = awake_oe ? awake_out : !ext_low;
endmodule

/* File: tb/suspend_wake_sequencer_bench.sv */
`timescale 1ns/1ps
module suspend_wake_sequencer_bench;
  logic        clk, rst_b, avs_read, avs_write, avs_waitrequest, suspend_in, awake_in, awake_out, awake_oe;
  logic        config_done, sleep_ack_in, sleep_request_out, global_write_en, outputs_sleep, input_block;
  logic        capture_hold, global_set_reset, ext_low;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [7:0]  wake_pin, ack_wait, oc, wc, mask;
  logic [4:0]  ctrl;
  logic [31:0] exp_q[$];  // expected read data, oldest first
  int          error_cnt = 0, compares = 0, cyc = 0, t0, t1, t2;
  suspend_wake_sequencer u_suspend_wake_sequencer (.clk, .rst_b, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .suspend_in, .wake_pin, .awake_in, .awake_out, .awake_oe,
    .config_done, .sleep_ack_in, .sleep_request_out, .global_write_en, .outputs_sleep, .input_block,
    .capture_hold, .global_set_reset);
  sys_ctrl_model u_sys_ctrl_model (.clk, .rst_b, .sleep_request_out, .awake_out, .awake_oe, .sleep_ack_in,
    .awake_in, .ack_wait, .ext_low);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  ////////////////////////////////
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // one access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) check("waitrequest", 0, 1);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  // bounded wait on one pin: 0 awake wire, 1 outputs_sleep, 2 write enable, 3 input_block
  task automatic wait_sig(input int s, input logic lvl, input int lim);
    int n;
    logic v;
    n = 0;
    do begin
      @(posedge clk);
      v = (s == 0) ? awake_in : (s == 1) ? outputs_sleep : (s == 2) ? global_write_en : input_block;
      n++;
    end while (v !== lvl && n < lim);
    if (v !== lvl) check("wait level", lvl, v);
  endtask
  // read data checked at the accepting edge
  always @(posedge clk) begin
    if (avs_read && !avs_waitrequest && exp_q.size() > 0) check("readdata", exp_q.pop_front(), avs_readdata);
  end
  initial begin
    #500000;
    error_cnt++;
    wrap_up();
  end
  ////////////////////////////////
  initial begin
    {rst_b, avs_read, avs_write, suspend_in, ext_low} = 5'h00;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    wake_pin = 8'h00;
    ack_wait = 8'h00;
    void'($urandom(82));
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    // defaults, unmapped and read-only places
    rd(4'h0, 32'h0);
    rd(4'h4, 32'h0);
    rd(4'h8, 32'h0504);
    bus(1'b1, 4'h2, 32'hFF);
    bus(1'b1, 4'hC, 32'hFF);
    rd(4'h2, 32'h0);
    rd(4'hC, 32'h88);
    check("config_done", 1, config_done);
    $display("test registers done");
    // feature off: suspend must change nothing
    suspend_in <= 1'b1;
    repeat (30) @(posedge clk);
    check("off write enable", 1, global_write_en);
    suspend_in <= 1'b0;
    $display("test disabled done");
    // modes: plain drive, handshake open drain, multi-pin open drain
    for (int m = 0; m < 3; m++) begin
      oc = 8'(1 + $urandom % 6);
      wc = 8'(oc + 1 + $urandom % 4);
      ctrl = (m == 0) ? 5'h09 : (m == 1) ? 5'h13 : 5'h05;
      mask = 8'h01 << ($urandom % 8);
      ack_wait <= 8'd20;
      wake_pin <= 8'h00;
      bus(1'b1, 4'h8, {16'h0, wc, oc});
      bus(1'b1, 4'h4, {24'h0, mask});
      bus(1'b1, 4'h0, {27'h0, ctrl});
      rd(4'h8, {16'h0, wc, oc});
      suspend_in <= 1'b1;
      if (ctrl[1]) begin
        repeat (12) @(posedge clk);
        check("request", 1, sleep_request_out);
        check("ack wait", 1, global_write_en);
      end
      wait_sig(3, 1'b1, 100);
      rd(4'hC, {24'h0, 1'b0, ctrl[1], 6'h33});
      check("done asleep", 1, config_done);
      ext_low <= (m == 1);
      suspend_in <= 1'b0;
      if (ctrl[2]) begin
        wake_pin <= ~mask;
        repeat (40) @(posedge clk);
        check("masked pins", 1, input_block);
        wake_pin <= mask;
      end
      if (m == 1) begin
        repeat (60) @(posedge clk);
        check("awake held", 1, outputs_sleep);
        ext_low <= 1'b0;
      end
      wait_sig(0, 1'b1, 200);
      t0 = cyc;
      wait_sig(1, 1'b0, 100);
      t1 = cyc;
      wait_sig(2, 1'b1, 100);
      t2 = cyc;
      check("out release", 1, (t1 - t0 >= oc + 1) && (t1 - t0 <= oc + 4));
      check("write release", 32'(wc - oc), 32'(t2 - t1));
      repeat (4) @(posedge clk);
      rd(4'hC, 32'h88);
      $display("test mode %0d done", m);
    end
    repeat (5) @(posedge clk);
    wrap_up();
  end
endmodule
